// >>> design/eeprom_core.sv
`timescale 1ns/1ps
module eeprom_core (
    input wire logic i_clk,
    input wire logic i_reset_n,
    eeprom_sfr_if.core bus,
    input wire logic i_req,
    input wire logic i_req_write,
    input wire logic [7:0] i_req_addr,
    input wire logic [7:0] i_req_data,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_global_interrupt_enable
);

    // ********************************
    // State
    // ********************************
    typedef enum logic [3:0] {
        S_IDLE, S_PTR, S_RD_EN, S_RD_ADDR, S_RD_GO, S_WR_ADDR, S_WR_DATA,
        S_WR_EN, S_WR_GO, S_GIE_ON, S_POLL, S_POLL_WAIT, S_POLL_EVAL,
        S_CLEAN, S_FETCH, S_FETCH_WAIT
    } step_t;

    typedef struct packed {
        step_t step;
        logic is_write;
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] pointer_one_low;
        logic [7:0] pointer_one_high;
        logic [7:0] sfr_addr;
        logic sfr_wr;
        logic sfr_rd;
        logic [7:0] sfr_wdata;
        logic flag_clear;
        logic busy;
        logic done;
        logic [7:0] rdata;
        logic gie;
    } core_t;

    core_t st_r;
    core_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sfr_wr = 1'b0;
        st_nxt.sfr_rd = 1'b0;
        st_nxt.flag_clear = 1'b0;
        st_nxt.done = 1'b0;
        unique case (st_r.step)
            S_IDLE:
            begin
                if (i_req)
                begin
                    st_nxt.is_write = i_req_write;
                    st_nxt.addr = i_req_addr;
                    st_nxt.data = i_req_data;
                    st_nxt.busy = 1'b1;
                    st_nxt.step = S_PTR;
                end
            end
            S_PTR:
            begin
                st_nxt.pointer_one_low = eeprom_pkg::CTRL_OFFSET;
                st_nxt.pointer_one_high = eeprom_pkg::CTRL_SECTOR;
                st_nxt.step = st_r.is_write ? S_WR_ADDR : S_RD_EN;
            end
            S_RD_EN:
            begin
                st_nxt.sfr_wr = 1'b1;
                st_nxt.sfr_addr = st_r.pointer_one_low;
                st_nxt.sfr_wdata = eeprom_pkg::CTRL_READ_EN;
                st_nxt.step = S_RD_ADDR;
            end
            S_RD_ADDR, S_WR_ADDR:
            begin
                st_nxt.sfr_wr = 1'b1;
                st_nxt.sfr_addr = eeprom_pkg::ADDR_OFFSET;
                st_nxt.sfr_wdata = st_r.addr;
                st_nxt.step = st_r.is_write ? S_WR_DATA : S_RD_GO;
            end
            S_RD_GO:
            begin
                st_nxt.sfr_wr = 1'b1;
                st_nxt.sfr_addr = st_r.pointer_one_low;
                st_nxt.sfr_wdata = eeprom_pkg::CTRL_READ_GO;
                st_nxt.step = S_POLL;
            end
            S_WR_DATA:
            begin
                st_nxt.sfr_wr = 1'b1;
                st_nxt.sfr_addr = eeprom_pkg::DATA_OFFSET;
                st_nxt.sfr_wdata = st_r.data;
                st_nxt.gie = 1'b0;
                st_nxt.step = S_WR_EN;
            end
            S_WR_EN:
            begin
                st_nxt.sfr_wr = 1'b1;
                st_nxt.sfr_addr = st_r.pointer_one_low;
                st_nxt.sfr_wdata = eeprom_pkg::CTRL_WRITE_EN;
                st_nxt.step = S_WR_GO;
            end
            S_WR_GO:
            begin
                // Back to back with the enable write, nothing between
                st_nxt.sfr_wr = 1'b1;
                st_nxt.sfr_addr = st_r.pointer_one_low;
                st_nxt.sfr_wdata = eeprom_pkg::CTRL_WRITE_GO;
                st_nxt.step = S_GIE_ON;
            end
            S_GIE_ON:
            begin
                st_nxt.gie = 1'b1;
                st_nxt.step = S_POLL;
            end
            S_POLL:
            begin
                st_nxt.sfr_rd = 1'b1;
                st_nxt.sfr_addr = st_r.pointer_one_low;
                st_nxt.step = S_POLL_WAIT;
            end
            S_POLL_WAIT:
            begin
                st_nxt.step = S_POLL_EVAL;
            end
            S_POLL_EVAL:
            begin
                // Completion seen through the start bit
                if (bus.sfr_rdata[st_r.is_write ? eeprom_pkg::WR_BIT
                                                : eeprom_pkg::RD_BIT])
                begin
                    st_nxt.step = S_POLL;
                end
                else
                begin
                    st_nxt.sfr_wr = 1'b1;
                    st_nxt.sfr_addr = st_r.pointer_one_low;
                    st_nxt.sfr_wdata = eeprom_pkg::CTRL_OFF;
                    st_nxt.flag_clear = st_r.is_write;
                    st_nxt.step = S_CLEAN;
                end
            end
            S_CLEAN:
            begin
                // Sector 0 again keeps stray writes off control
                st_nxt.pointer_one_high = eeprom_pkg::SECTOR_ZERO;
                if (st_r.is_write)
                begin
                    st_nxt.busy = 1'b0;
                    st_nxt.done = 1'b1;
                    st_nxt.step = S_IDLE;
                end
                else
                begin
                    st_nxt.sfr_rd = 1'b1;
                    st_nxt.sfr_addr = eeprom_pkg::DATA_OFFSET;
                    st_nxt.step = S_FETCH;
                end
            end
            S_FETCH:
            begin
                st_nxt.step = S_FETCH_WAIT;
            end
            S_FETCH_WAIT:
            begin
                st_nxt.rdata = bus.sfr_rdata;
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
                st_nxt.step = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_r <= '0;
            st_r.step <= S_IDLE;
            st_r.gie <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign bus.sfr_addr = st_r.sfr_addr;
    assign bus.sfr_sector = st_r.pointer_one_high;
    assign bus.sfr_wr = st_r.sfr_wr;
    assign bus.sfr_rd = st_r.sfr_rd;
    assign bus.sfr_wdata = st_r.sfr_wdata;
    assign bus.flag_clear = st_r.flag_clear;
    assign o_busy = st_r.busy;
    assign o_done = st_r.done;
    assign o_rdata = st_r.rdata;
    assign o_global_interrupt_enable = st_r.gie;

endmodule : eeprom_core

// >>> design/eeprom_device.sv
`timescale 1ns/1ps
// Contract
// - Byte array, 64, 128 or 256 deep
// - One byte per cycle via address/data
// - Control reached indirectly, pointer 40H/01H
// - Address keeps needed bits, rest zero
// - Control bits 7..4 read zero
// - Write enable gates every write
// - Write start needs prior enable; auto-clears
// - Read enable gates every read
// - Read start needs prior enable; auto-clears
// - No enable+start together, no read+write
// - Read: enable, address, start, poll
// - Read byte held in data register
// - Load address and data before write
// - Write start right after write enable
// - Mask global interrupt around write start
// - Write length set by free timer
// - Write end seen on start bit, flag
// - Write end sets done and shared flag
// - Write enable clear at power-on
// - No sleep while access pending
module eeprom_device #(
    parameter int DEPTH = eeprom_pkg::DEPTH_LARGE
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    eeprom_sfr_if.device bus,
    output logic o_busy
);

    localparam int AW = $clog2(DEPTH);

    // ********************************
    // State
    // ********************************
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_READ,
        PH_WRITE
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [AW-1:0] addr;
        logic [7:0] data;
        logic wr_en;
        logic wr;
        logic rd_en;
        logic rd;
        logic [eeprom_pkg::CNT_W-1:0] cnt;
        logic [7:0] lfsr;
        logic [7:0] rdata;
        logic done_flag;
        logic mf_pulse;
        logic busy;
        logic [DEPTH-1:0][7:0] mem;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // ********************************
    // Helpers
    // ********************************
    function automatic logic hits(
        input logic [7:0] a,
        input logic [7:0] s,
        input logic [7:0] off,
        input logic indirect
    );
        if (indirect)
        begin
            return (a == off) && (s == eeprom_pkg::CTRL_SECTOR);
        end
        return a == off;
    endfunction : hits

    function automatic logic [7:0] lfsr_step(input logic [7:0] v);
        if (v[0])
        begin
            return (v >> 1) ^ eeprom_pkg::LFSR_TAPS;
        end
        return v >> 1;
    endfunction : lfsr_step

    function automatic logic [7:0] ctrl_byte(input state_t s);
        logic [7:0] b;
        b = eeprom_pkg::BYTE_ZERO;
        b[eeprom_pkg::WRITE_EN_BIT] = s.wr_en;
        b[eeprom_pkg::WR_BIT] = s.wr;
        b[eeprom_pkg::READ_EN_BIT] = s.rd_en;
        b[eeprom_pkg::RD_BIT] = s.rd;
        return b;
    endfunction : ctrl_byte

    logic sel_ctrl;
    logic sel_addr;
    logic sel_data;

    always_comb
    begin
        // Control sits in sector 1 only; address/data in every sector
        sel_ctrl = hits(bus.sfr_addr, bus.sfr_sector,
                        eeprom_pkg::CTRL_OFFSET, 1'b1);
        sel_addr = hits(bus.sfr_addr, bus.sfr_sector,
                        eeprom_pkg::ADDR_OFFSET, 1'b0);
        sel_data = hits(bus.sfr_addr, bus.sfr_sector,
                        eeprom_pkg::DATA_OFFSET, 1'b0);
    end

    // ********************************
    // Next state
    // ********************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.mf_pulse = 1'b0;
        st_nxt.lfsr = lfsr_step(st_r.lfsr);

        if (bus.sfr_rd)
        begin
            if (sel_ctrl)
            begin
                st_nxt.rdata = ctrl_byte(st_r);
            end
            else if (sel_addr)
            begin
                st_nxt.rdata = 8'(st_r.addr);
            end
            else if (sel_data)
            begin
                st_nxt.rdata = st_r.data;
            end
            else
            begin
                st_nxt.rdata = eeprom_pkg::BYTE_ZERO;
            end
        end

        if (bus.sfr_wr && st_r.phase == PH_IDLE)
        begin
            // Frozen while a cycle runs so the cycle sees stable operands
            if (sel_addr)
            begin
                st_nxt.addr = bus.sfr_wdata[AW-1:0];
            end
            if (sel_data)
            begin
                st_nxt.data = bus.sfr_wdata;
            end
        end

        if (bus.sfr_wr && sel_ctrl)
        begin
            st_nxt.wr_en = bus.sfr_wdata[eeprom_pkg::WRITE_EN_BIT];
            st_nxt.rd_en = bus.sfr_wdata[eeprom_pkg::READ_EN_BIT];
            // Start only honoured against the enable already stored
            if (st_r.phase == PH_IDLE)
            begin
                if (bus.sfr_wdata[eeprom_pkg::WR_BIT] && st_r.wr_en)
                begin
                    st_nxt.wr = 1'b1;
                    st_nxt.phase = PH_WRITE;
                    st_nxt.cnt = eeprom_pkg::CNT_W'(eeprom_pkg::WRITE_CYCLES)
                        + eeprom_pkg::CNT_W'(
                              st_r.lfsr[eeprom_pkg::JITTER_W-1:0]);
                end
                else if (bus.sfr_wdata[eeprom_pkg::RD_BIT] && st_r.rd_en)
                begin
                    st_nxt.rd = 1'b1;
                    st_nxt.phase = PH_READ;
                    st_nxt.cnt = eeprom_pkg::CNT_W'(eeprom_pkg::READ_CYCLES);
                end
            end
        end

        if (bus.flag_clear)
        begin
            st_nxt.done_flag = 1'b0;
        end

        unique case (st_r.phase)
            PH_IDLE:
            begin
            end
            PH_READ:
            begin
                st_nxt.cnt = st_r.cnt - 1'b1;
                if (st_r.cnt == 1'b1)
                begin
                    st_nxt.data = st_r.mem[st_r.addr];
                    st_nxt.rd = 1'b0;
                    st_nxt.phase = PH_IDLE;
                end
            end
            PH_WRITE:
            begin
                st_nxt.cnt = st_r.cnt - 1'b1;
                if (st_r.cnt == 1'b1)
                begin
                    // Enable dropped mid-cycle cancels the store
                    if (st_r.wr_en)
                    begin
                        st_nxt.mem[st_r.addr] = st_r.data;
                    end
                    st_nxt.wr = 1'b0;
                    st_nxt.done_flag = 1'b1;
                    st_nxt.mf_pulse = 1'b1;
                    st_nxt.phase = PH_IDLE;
                end
            end
        endcase

        st_nxt.busy = st_nxt.phase != PH_IDLE;
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_r <= '0;
            st_r.phase <= PH_IDLE;
            st_r.lfsr <= eeprom_pkg::LFSR_SEED;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign bus.sfr_rdata = st_r.rdata;
    assign bus.write_done_flag = st_r.done_flag;
    assign bus.multi_func_flag = st_r.mf_pulse;
    assign o_busy = st_r.busy;

endmodule : eeprom_device

// >>> design/eeprom_pkg.sv
package eeprom_pkg;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int WRITE_TIME_NS = 1000;
    localparam int READ_TIME_NS = 20;
    localparam int WRITE_CYCLES =
        (WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int READ_CYCLES =
        (READ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 9;
    localparam int JITTER_W = 4;

    // ********************************
    // Array
    // ********************************
    localparam int DEPTH_SMALL = 64;
    localparam int DEPTH_MID = 128;
    localparam int DEPTH_LARGE = 256;

    // ********************************
    // Register map
    // ********************************
    localparam logic [7:0] CTRL_OFFSET = 8'h40;
    localparam logic [7:0] CTRL_SECTOR = 8'h01;
    localparam logic [7:0] SECTOR_ZERO = 8'h00;
    localparam logic [7:0] ADDR_OFFSET = 8'h1E;
    localparam logic [7:0] DATA_OFFSET = 8'h1F;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    localparam int WRITE_EN_BIT = 3;
    localparam int WR_BIT = 2;
    localparam int READ_EN_BIT = 1;
    localparam int RD_BIT = 0;

    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] CTRL_READ_EN = 8'h02;
    localparam logic [7:0] CTRL_READ_GO = 8'h03;
    localparam logic [7:0] CTRL_WRITE_EN = 8'h08;
    localparam logic [7:0] CTRL_WRITE_GO = 8'h0C;

    // ********************************
    // Write timer jitter source
    // ********************************
    localparam logic [7:0] LFSR_SEED = 8'h01;
    localparam logic [7:0] LFSR_TAPS = 8'hB8;

endpackage : eeprom_pkg

// >>> design/eeprom_sfr_if.sv
`timescale 1ns/1ps
interface eeprom_sfr_if;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_sector;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic flag_clear;
    logic [7:0] sfr_rdata;
    logic write_done_flag;
    logic multi_func_flag;

    modport device (
        input sfr_addr, sfr_sector, sfr_wr, sfr_rd, sfr_wdata, flag_clear,
        output sfr_rdata, write_done_flag, multi_func_flag
    );
    modport core (
        output sfr_addr, sfr_sector, sfr_wr, sfr_rd, sfr_wdata, flag_clear,
        input sfr_rdata, write_done_flag, multi_func_flag
    );
endinterface : eeprom_sfr_if

// >>> testbench/data_eeprom_byte_access_test.sv
`timescale 1ns/1ps
module data_eeprom_byte_access_test;
    localparam int LIMIT = 20000;
    localparam int WR_N = eeprom_pkg::WRITE_CYCLES;
    localparam logic [7:0] CT = eeprom_pkg::CTRL_OFFSET;
    localparam logic [7:0] S1 = eeprom_pkg::CTRL_SECTOR;
    localparam logic [7:0] S0 = eeprom_pkg::SECTOR_ZERO;
    localparam logic [7:0] AR = eeprom_pkg::ADDR_OFFSET;
    localparam logic [7:0] DR = eeprom_pkg::DATA_OFFSET;
    logic i_clk;
    logic i_reset_n;
    logic i_req;
    logic i_req_write;
    logic [7:0] i_req_addr;
    logic [7:0] i_req_data;
    logic o_busy;
    logic core_busy;
    logic o_done;
    logic [7:0] o_rdata;
    logic gie;
    logic busy_b;
    logic gie_low_seen;
    logic [7:0] v;
    logic [7:0] ref_mem [256];
    logic [31:0] seed;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int wait_n;

    eeprom_sfr_if bus ();
    // Second device driven straight from the bench, small array
    eeprom_sfr_if bus_b ();

    eeprom_device u_eeprom_device (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .bus(bus.device), .o_busy(o_busy));
    eeprom_device #(.DEPTH(eeprom_pkg::DEPTH_SMALL)) u_eeprom_device_b (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus_b.device),
        .o_busy(busy_b));
    eeprom_core u_eeprom_core (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .bus(bus.core), .i_req(i_req), .i_req_write(i_req_write),
        .i_req_addr(i_req_addr), .i_req_data(i_req_data),
        .o_busy(core_busy), .o_done(o_done), .o_rdata(o_rdata),
        .o_global_interrupt_enable(gie));
    eeprom_sva u_eeprom_sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .sfr_addr(bus.sfr_addr), .sfr_sector(bus.sfr_sector),
        .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd),
        .sfr_wdata(bus.sfr_wdata), .flag_clear(bus.flag_clear),
        .sfr_rdata(bus.sfr_rdata), .write_done_flag(bus.write_done_flag),
        .multi_func_flag(bus.multi_func_flag));

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            end_sim();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    // Strobe stays up so back-to-back writes land on successive edges
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] s,
                             input logic [7:0] d);
        @(negedge i_clk);
        bus_b.sfr_addr = a;
        bus_b.sfr_sector = s;
        bus_b.sfr_wdata = d;
        bus_b.sfr_rd = 1'b0;
        bus_b.sfr_wr = 1'b1;
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] a, input logic [7:0] s);
        @(negedge i_clk);
        bus_b.sfr_addr = a;
        bus_b.sfr_sector = s;
        bus_b.sfr_wr = 1'b0;
        bus_b.sfr_rd = 1'b1;
        @(negedge i_clk);
        bus_b.sfr_rd = 1'b0;
        v = bus_b.sfr_rdata;
    endtask : sfr_read

    task automatic bus_idle();
        @(negedge i_clk);
        bus_b.sfr_wr = 1'b0;
        bus_b.flag_clear = 1'b0;
    endtask : bus_idle

    task automatic run_op(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge i_clk);
        {i_req, i_req_write, i_req_addr, i_req_data} = {1'b1, w, a, d};
        gie_low_seen = 1'b0;
        wait_n = 0;
        @(negedge i_clk);
        i_req = 1'b0;
        check({7'h00, core_busy}, 8'h01);
        while (o_done !== 1'b1 && wait_n < 1000)
        begin
            @(negedge i_clk);
            wait_n++;
            if (gie === 1'b0)
                gie_low_seen = 1'b1;
            if (w && wait_n == 100)
                check({7'h00, o_busy}, 8'h01);
        end
        check({7'h00, o_done}, 8'h01);
        check({6'h00, core_busy, o_busy}, 8'h00);
        if (w)
        begin
            ref_mem[a] = d;
            check({7'h00, wait_n >= WR_N}, 8'h01);
            check({6'h00, gie_low_seen, gie}, 8'h03);
        end
        else
            check(o_rdata, ref_mem[a]);
    endtask : run_op

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {i_reset_n, i_req, i_req_write, i_req_addr, i_req_data} = '0;
        {bus_b.sfr_addr, bus_b.sfr_sector, bus_b.sfr_wdata} = '0;
        {bus_b.sfr_wr, bus_b.sfr_rd, bus_b.flag_clear} = '0;
        gie_low_seen = 1'b0;
        seed = 32'h0001_56C8;
        foreach (ref_mem[i])
            ref_mem[i] = 8'h00;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_reset_n = 1'b1;
        sfr_read(CT, S1);
        check(v, 8'h00);
        sfr_write(AR, S0, 8'hFF);
        sfr_read(AR, S0);
        check(v, 8'h3F);
        sfr_write(CT, S0, 8'h08);
        sfr_write(CT, S1, 8'hF4);
        sfr_read(CT, S1);
        check(v, 8'h00);
        sfr_write(CT, S1, 8'h01);
        sfr_read(CT, S1);
        check(v, 8'h00);
        check({7'h00, busy_b}, 8'h00);
        sfr_write(AR, S0, 8'h25);
        sfr_write(DR, S0, 8'hA5);
        sfr_write(CT, S1, 8'h08);
        sfr_write(CT, S1, 8'h0C);
        bus_idle();
        sfr_write(AR, S0, 8'h11);
        sfr_read(CT, S1);
        check(v, 8'h0C);
        sfr_read(AR, S0);
        check(v, 8'h25);
        check({7'h00, busy_b}, 8'h01);
        sfr_read(8'h20, S0);
        check(v, 8'h00);
        wait_n = 0;
        while (bus_b.write_done_flag !== 1'b1 && wait_n < 400)
        begin
            @(negedge i_clk);
            wait_n++;
        end
        check({7'h00, wait_n > WR_N - 10}, 8'h01);
        check({7'h00, bus_b.write_done_flag}, 8'h01);
        sfr_read(CT, S1);
        check(v, 8'h08);
        @(negedge i_clk);
        bus_b.flag_clear = 1'b1;
        bus_idle();
        check({7'h00, bus_b.write_done_flag}, 8'h00);
        sfr_write(CT, S1, 8'h02);
        sfr_write(DR, S0, 8'h00);
        sfr_write(CT, S1, 8'h03);
        wait_n = 0;
        v = 8'h03;
        while (v[0] !== 1'b0 && wait_n < 50)
        begin
            sfr_read(CT, S1);
            wait_n++;
        end
        check(v, 8'h02);
        sfr_read(DR, S0);
        check(v, 8'hA5);
        run_op(1'b1, 8'h00, 8'hFF);
        run_op(1'b1, 8'hFF, 8'h5A);
        run_op(1'b0, 8'h80, 8'h00);
        run_op(1'b0, 8'h00, 8'h00);
        run_op(1'b0, 8'hFF, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr_next(seed);
            run_op(seed[12], seed[7:0] & 8'hC7, seed[23:16]);
        end
        end_sim();
    end
endmodule : data_eeprom_byte_access_test

// >>> testbench/eeprom_sva.sv
`timescale 1ns/1ps
module eeprom_sva (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_sector,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic flag_clear,
    input wire logic [7:0] sfr_rdata,
    input wire logic write_done_flag,
    input wire logic multi_func_flag
);
    logic ctrl_sel;
    logic rd_en_r;

    assign ctrl_sel = (sfr_addr == eeprom_pkg::CTRL_OFFSET)
        && (sfr_sector == eeprom_pkg::CTRL_SECTOR);

    // Read enable as last written, so a start can be judged against it
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rd_en_r <= 1'b0;
        end
        else if (sfr_wr && ctrl_sel)
        begin
            rd_en_r <= sfr_wdata[eeprom_pkg::READ_EN_BIT];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    shared_pulse_a: assert property (
        multi_func_flag |=> !multi_func_flag)
        else $error("shared request longer than one cycle");
    done_with_shared_a: assert property (
        multi_func_flag |-> write_done_flag)
        else $error("shared request without done flag");
    done_rise_a: assert property (
        $rose(write_done_flag) |-> multi_func_flag)
        else $error("done flag rose alone");
    done_sticky_a: assert property (
        write_done_flag && !flag_clear |=> write_done_flag)
        else $error("done flag dropped without clear");
    rdata_hold_a: assert property (
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    ctrl_upper_zero_a: assert property (
        sfr_rd && ctrl_sel |=> sfr_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    wr_bit_clear_a: assert property (
        sfr_rd && ctrl_sel |=> !(sfr_rdata[2] && $past(write_done_flag)))
        else $error("start bit still set after write end");
    start_after_enable_a: assert property (
        sfr_wr && ctrl_sel && sfr_wdata[2] |-> $past(sfr_wr)
        && $past(ctrl_sel) && $past(sfr_wdata) == 8'h08)
        else $error("write start not right after enable");
    read_start_enabled_a: assert property (
        sfr_wr && ctrl_sel && sfr_wdata[0] |-> rd_en_r)
        else $error("read start before read enable");
    no_dual_start_a: assert property (
        sfr_wr && ctrl_sel |-> !(sfr_wdata[2] && sfr_wdata[0]))
        else $error("read and write started together");
    ctrl_sector_a: assert property (
        sfr_wr && sfr_addr == 8'h40 |-> sfr_sector == 8'h01)
        else $error("control written outside its sector");
    write_ends_a: assert property (
        sfr_wr && ctrl_sel && sfr_wdata[2] |-> ##[180:260] multi_func_flag)
        else $error("write cycle did not end in time");

    // ****************************************
    // Coverage
    // ****************************************
    cover property (multi_func_flag);
    cover property (sfr_rd && ctrl_sel ##1 sfr_rdata[0]);
    cover property (flag_clear && write_done_flag);
endmodule : eeprom_sva
